/* stcap_timer.sv */
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module stcap_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        gpio_in,
   input  wire logic        real_time_clock_source,
   input  wire logic        external_fast_oscillator,
   input  wire logic        main_clock_output,
   input  wire logic        filtered_input_two,
   input  wire logic        trigger_in,
   output logic             channel_one_output,
   output logic             channel_output_enable,
   output logic             compare_reference_signal,
   output logic             update_event,
   output logic             irq
);
   // ======================================================
   // state
   logic [15:0] counter_value_r;
   logic [15:0] prescaler_divisor_r;
   logic [15:0] div_shadow_r;
   logic [15:0] div_count_r;
   logic [15:0] period_limit_r;
   logic [15:0] channel_one_value_r;
   logic [15:0] cmp_act_r;
   logic [1:0]  input_remap_field_r;
   logic [1:0]  channel_mode_select_r;
   logic        compare_preload_enable_r;
   logic        channel_enable_bit_r;
   logic        main_polarity_bit_r;
   logic        complementary_polarity_bit_r;
   logic [1:0]  sts_r;
   logic [1:0]  sts_nxt;
   logic [1:0]  mask_r;
   logic        cap_prev_r;
   logic [31:0] rd_nxt;
   logic        unmapped;
   // ======================================================
   // apb decode
   logic wr_en;
   logic setup;
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready;

   function automatic logic hit(input logic [7:0] off);
      hit = wr_en && (paddr == off);
   endfunction : hit

   // edge qualification shared by every capture source
   function automatic logic edge_hit(input logic cur, input logic prev,
                                     input logic npol, input logic pol);
      logic rise;
      logic fall;
      rise = cur & ~prev;
      fall = ~cur & prev;
      case ({npol, pol})
         2'b01:   edge_hit = fall;
         2'b11:   edge_hit = rise | fall;
         default: edge_hit = rise;                      // reserved code acts as rising
      endcase
   endfunction : edge_hit

   // ======================================================
   // input routing and capture event
   logic filtered_input_one;
   logic cap_src;
   logic cap_evt;
   logic in_mode;
   always_comb begin
      case (stcap_pkg::stcap_rmp_e'(input_remap_field_r))
         stcap_pkg::STCAP_RMP_RTC: filtered_input_one = real_time_clock_source;
         stcap_pkg::STCAP_RMP_HSE: filtered_input_one = external_fast_oscillator;
         stcap_pkg::STCAP_RMP_CLKO: filtered_input_one = main_clock_output;
         default:                  filtered_input_one = gpio_in;
      endcase
      case (stcap_pkg::stcap_mode_e'(channel_mode_select_r))
         stcap_pkg::STCAP_IN2: cap_src = filtered_input_two;
         stcap_pkg::STCAP_TRG: cap_src = trigger_in;
         default:              cap_src = filtered_input_one;
      endcase
   end
   assign in_mode = (channel_mode_select_r != stcap_pkg::STCAP_OUT);
   // one polarity setting serves all three capture sources (IN1, IN2, TRG)
   assign cap_evt = in_mode & channel_enable_bit_r
                  & edge_hit(cap_src, cap_prev_r, complementary_polarity_bit_r, main_polarity_bit_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_prev_r <= 1'b0;
      end else begin
         cap_prev_r <= cap_src;
      end
   end

   // ======================================================
   // prescaler and counter
   logic tick;
   logic upd;
   logic cnt_wr;
   assign tick   = (div_count_r == div_shadow_r);
   assign cnt_wr = wr_en && (paddr == stcap_pkg::OFF_CNT);
   assign upd    = tick & (period_limit_r != 16'h0000) & (counter_value_r == period_limit_r) & ~cnt_wr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count_r  <= 16'h0000;
         div_shadow_r <= stcap_pkg::PRESC_RST;
      end else begin
         // divisor is buffered so a change lands at a period boundary
         if (upd) begin
            div_shadow_r <= prescaler_divisor_r;
         end
         if (tick) begin
            div_count_r <= 16'h0000;
         end else begin
            div_count_r <= div_count_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_value_r <= stcap_pkg::CNT_RST;
      end else if (cnt_wr) begin
         counter_value_r <= pwdata[15:0];
      end else if (tick && period_limit_r != 16'h0000) begin
         if (upd) begin
            counter_value_r <= 16'h0000;
         end else begin
            counter_value_r <= counter_value_r + 16'h0001;
         end
      end
   end

   // ======================================================
   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_divisor_r <= stcap_pkg::PRESC_RST;
         period_limit_r      <= stcap_pkg::ARR_RST;
         input_remap_field_r <= stcap_pkg::OPT_RST;
         mask_r              <= 2'b00;
      end else begin
         if (hit(stcap_pkg::OFF_PRESC)) begin
            prescaler_divisor_r <= pwdata[15:0];
         end
         if (hit(stcap_pkg::OFF_ARR)) begin
            period_limit_r <= pwdata[15:0];
         end
         if (hit(stcap_pkg::OFF_OPT)) begin
            input_remap_field_r <= pwdata[1:0];
         end
         if (hit(stcap_pkg::OFF_MASK)) begin
            mask_r <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_mode_select_r    <= stcap_pkg::STCAP_OUT;
         compare_preload_enable_r <= 1'b0;
      end else if (hit(stcap_pkg::OFF_MODE)) begin
         compare_preload_enable_r <= pwdata[stcap_pkg::MODE_PEN];
         if (!channel_enable_bit_r) begin
            channel_mode_select_r <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_enable_bit_r         <= 1'b0;
         main_polarity_bit_r          <= 1'b0;
         complementary_polarity_bit_r <= 1'b0;
      end else begin
         if (hit(stcap_pkg::OFF_CCEN)) begin
            channel_enable_bit_r <= pwdata[stcap_pkg::CCEN_EN];
            main_polarity_bit_r  <= pwdata[stcap_pkg::CCEN_POL];
         end
         // a stale bit from input mode is dropped when output mode is chosen
         if (!in_mode) begin
            complementary_polarity_bit_r <= 1'b0;
         end else if (hit(stcap_pkg::OFF_CCEN)) begin
            complementary_polarity_bit_r <= pwdata[stcap_pkg::CCEN_NPOL];
         end
      end
   end

   // ======================================================
   // channel value and compare shadow
   logic cc_wr;
   assign cc_wr = wr_en && (paddr == stcap_pkg::OFF_CHVAL);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_one_value_r <= stcap_pkg::CHVAL_RST;
      end else if (cap_evt) begin
         channel_one_value_r <= counter_value_r;
      end else if (cc_wr) begin
         channel_one_value_r <= pwdata[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_act_r <= stcap_pkg::CHVAL_RST;
      end else if (cc_wr && !compare_preload_enable_r) begin
         cmp_act_r <= pwdata[15:0];
      end else if (upd && compare_preload_enable_r) begin
         cmp_act_r <= channel_one_value_r;
      end
   end

   // ======================================================
   // channel output, registered so pins never glitch
   logic ref_nxt;
   assign ref_nxt = (counter_value_r < cmp_act_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_reference_signal <= 1'b0;
         channel_one_output       <= 1'b0;
         channel_output_enable    <= 1'b0;
         update_event             <= 1'b0;
      end else begin
         compare_reference_signal <= ref_nxt & ~in_mode;
         channel_output_enable    <= channel_enable_bit_r & ~in_mode;
         channel_one_output       <= channel_enable_bit_r & ~in_mode
                                   & (ref_nxt ^ main_polarity_bit_r);
         update_event             <= upd;
      end
   end

   // ======================================================
   // status, mask and interrupt; a set beats a same-cycle clear
   always_comb begin
      sts_nxt = sts_r;
      if (hit(stcap_pkg::OFF_STS)) begin
         sts_nxt = sts_r & ~pwdata[1:0];
      end
      if (upd) begin
         sts_nxt[stcap_pkg::STS_UPD] = 1'b1;
      end
      if (cap_evt) begin
         sts_nxt[stcap_pkg::STS_CAP] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_r <= 2'b00;
         irq   <= 1'b0;
      end else begin
         sts_r <= sts_nxt;
         irq   <= |(sts_nxt & mask_r);
      end
   end

   // ======================================================
   // apb read path: data is captured in setup, answered in the one access cycle
   always_comb begin
      rd_nxt   = 32'h0000_0000;
      unmapped = 1'b0;
      if (paddr == stcap_pkg::OFF_CNT) begin
         rd_nxt[15:0] = counter_value_r;
      end else if (paddr == stcap_pkg::OFF_PRESC) begin
         rd_nxt[15:0] = prescaler_divisor_r;
      end else if (paddr == stcap_pkg::OFF_ARR) begin
         rd_nxt[15:0] = period_limit_r;
      end else if (paddr == stcap_pkg::OFF_CHVAL) begin
         rd_nxt[15:0] = channel_one_value_r;
      end else if (paddr == stcap_pkg::OFF_OPT) begin
         rd_nxt[1:0] = input_remap_field_r;
      end else if (paddr == stcap_pkg::OFF_CCEN) begin
         rd_nxt[stcap_pkg::CCEN_EN]   = channel_enable_bit_r;
         rd_nxt[stcap_pkg::CCEN_POL]  = main_polarity_bit_r;
         rd_nxt[stcap_pkg::CCEN_NPOL] = complementary_polarity_bit_r;
      end else if (paddr == stcap_pkg::OFF_MODE) begin
         rd_nxt[1:0]                 = channel_mode_select_r;
         rd_nxt[stcap_pkg::MODE_PEN] = compare_preload_enable_r;
      end else if (paddr == stcap_pkg::OFF_STS) begin
         rd_nxt[1:0] = sts_r;
      end else if (paddr == stcap_pkg::OFF_MASK) begin
         rd_nxt[1:0] = mask_r;
      end else begin
         unmapped = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= unmapped;
         prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ======================================================
   // assertions
   property p_npol_zero;
      @(posedge pclk) disable iff (!presetn)
      !in_mode |=> !complementary_polarity_bit_r;
   endproperty
   a_npol_zero: assert property (p_npol_zero) else $error("npol set in output mode");
   property p_off_low;
      @(posedge pclk) disable iff (!presetn)
      !channel_enable_bit_r |=> !channel_one_output && !channel_output_enable;
   endproperty
   a_off_low: assert property (p_off_low) else $error("disabled channel drives");
   property p_on_drive;
      @(posedge pclk) disable iff (!presetn)
      channel_enable_bit_r && !in_mode |=> channel_output_enable
         && (channel_one_output == (compare_reference_signal ^ $past(main_polarity_bit_r)));
   endproperty
   a_on_drive: assert property (p_on_drive) else $error("enabled output wrong");
   property p_stopped;
      @(posedge pclk) disable iff (!presetn)
      period_limit_r == 16'h0000 && !cnt_wr |=> $stable(counter_value_r);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter ran at zero limit");
   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
      upd |=> counter_value_r == 16'h0000 && sts_r[stcap_pkg::STS_UPD] && update_event;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap or update missing");
   property p_pre_hold;
      @(posedge pclk) disable iff (!presetn)
      compare_preload_enable_r && !upd |=> $stable(cmp_act_r);
   endproperty
   a_pre_hold: assert property (p_pre_hold) else $error("preload leaked early");
   property p_direct;
      @(posedge pclk) disable iff (!presetn)
      cc_wr && !compare_preload_enable_r |=> cmp_act_r == $past(pwdata[15:0]);
   endproperty
   a_direct: assert property (p_direct) else $error("direct write not applied");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      cap_evt |=> channel_one_value_r == $past(counter_value_r) && sts_r[stcap_pkg::STS_CAP];
   endproperty
   a_capture: assert property (p_capture) else $error("capture not latched");

   property p_gate;
      @(posedge pclk) disable iff (!presetn)
      in_mode && !channel_enable_bit_r && !cc_wr |=> $stable(channel_one_value_r);
   endproperty
   a_gate: assert property (p_gate) else $error("capture while disabled");

   property p_mode_lock;
      @(posedge pclk) disable iff (!presetn)
      channel_enable_bit_r |=> $stable(channel_mode_select_r);
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode changed while enabled");

   property p_div;
      @(posedge pclk) disable iff (!presetn)
      div_count_r <= div_shadow_r;
   endproperty
   a_div: assert property (p_div) else $error("prescaler overran");

   c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_evt);
   c_update:  cover property (@(posedge pclk) disable iff (!presetn) upd && compare_preload_enable_r);
   c_irq:     cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_out:     cover property (@(posedge pclk) disable iff (!presetn) $rose(channel_one_output));
endmodule : stcap_timer

/* stcap_pkg.sv */
package stcap_pkg;
   // ======================================================
   // register byte offsets
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_STS  = 8'h10;
   localparam logic [7:0] OFF_MODE = 8'h18;
   localparam logic [7:0] OFF_CCEN = 8'h20;
   localparam logic [7:0] OFF_CNT  = 8'h24;
   localparam logic [7:0] OFF_PRESC = 8'h28;
   localparam logic [7:0] OFF_ARR  = 8'h2c;
   localparam logic [7:0] OFF_CHVAL = 8'h34;
   localparam logic [7:0] OFF_OPT  = 8'h50;
   // ======================================================
   // field positions
   localparam int CCEN_EN   = 0;
   localparam int CCEN_POL  = 1;
   localparam int CCEN_NPOL = 3;
   localparam int MODE_PEN  = 3;
   localparam int STS_UPD   = 0;
   localparam int STS_CAP   = 1;
   // ======================================================
   // reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] PRESC_RST = 16'h0000;
   localparam logic [15:0] ARR_RST = 16'hffff;
   localparam logic [15:0] CHVAL_RST = 16'h0000;
   localparam logic [1:0]  OPT_RST = 2'h0;
   // ======================================================
   // channel mode select codes
   typedef enum logic [1:0] {
      STCAP_OUT = 2'b00,
      STCAP_IN1 = 2'b01,
      STCAP_IN2 = 2'b10,
      STCAP_TRG = 2'b11
   } stcap_mode_e;
   // input remap codes
   typedef enum logic [1:0] {
      STCAP_RMP_GPIO = 2'b00,
      STCAP_RMP_RTC  = 2'b01,
      STCAP_RMP_HSE  = 2'b10,
      STCAP_RMP_CLKO = 2'b11
   } stcap_rmp_e;
endpackage : stcap_pkg

/* stcap_tb.sv */
`timescale 1ns/1ps
module testbench;
   // ======================================================
   // signals
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [5:0]  src_r;
   logic        ch_out;
   logic        ch_oe;
   logic        ch_ref;
   logic        upd;
   logic        irq;
   logic [31:0] rng_r;
   logic [33:0] note_q[$];
   logic [33:0] note_m;
   int          err_total;
   int          checked;
   // capture cases: mode, remap, polarity code, source, enable, rising, captured
   localparam logic [11:0] CASES [12] = '{
      {2'h1, 2'h0, 2'h0, 3'h0, 3'h7}, {2'h1, 2'h1, 2'h0, 3'h1, 3'h7}, {2'h1, 2'h2, 2'h0, 3'h2, 3'h7},
      {2'h1, 2'h3, 2'h0, 3'h3, 3'h7}, {2'h2, 2'h0, 2'h0, 3'h4, 3'h7}, {2'h3, 2'h0, 2'h0, 3'h5, 3'h7},
      {2'h1, 2'h0, 2'h1, 3'h0, 3'h6}, {2'h1, 2'h0, 2'h1, 3'h0, 3'h5}, {2'h1, 2'h0, 2'h3, 3'h0, 3'h5},
      {2'h1, 2'h0, 2'h0, 3'h0, 3'h2}, {2'h1, 2'h1, 2'h0, 3'h0, 3'h6}, {2'h2, 2'h0, 2'h1, 3'h4, 3'h5}};

   always #12.5 pclk = ~pclk;

   stcap_timer u_dut (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .psel                     (psel),
      .penable                  (penable),
      .pwrite                   (pwrite),
      .paddr                    (paddr),
      .pwdata                   (pwdata),
      .prdata                   (prdata),
      .pready                   (pready),
      .pslverr                  (pslverr),
      .gpio_in                  (src_r[0]),
      .real_time_clock_source   (src_r[1]),
      .external_fast_oscillator (src_r[2]),
      .main_clock_output        (src_r[3]),
      .filtered_input_two       (src_r[4]),
      .trigger_in               (src_r[5]),
      .channel_one_output       (ch_out),
      .channel_output_enable    (ch_oe),
      .compare_reference_signal (ch_ref),
      .update_event             (upd),
      .irq                      (irq)
   );

   // ======================================================
   // reporting
   task automatic miss(input logic [31:0] got, input logic [31:0] exp);
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
   endtask : miss

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) miss(got, exp);
   endtask : chk

   task automatic complete_run;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   function automatic logic [31:0] xs();
      rng_r = rng_r ^ (rng_r << 13);
      rng_r = rng_r ^ (rng_r >> 17);
      rng_r = rng_r ^ (rng_r << 5);
      return rng_r;
   endfunction : xs

   // ======================================================
   // apb master, notes the expected answer before each transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      note_q.push_back({w, e});
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) begin
         miss(32'h0, 32'h1);
         complete_run();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask : rd

   // write data is not compared, only the error flag
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         note_m = note_q.pop_front();
         checked++;
         if ({pslverr, note_m[33] ? 32'h0 : prdata} !== note_m[32:0]) miss(prdata, note_m[31:0]);
      end
   end

   // ======================================================
   // helpers
   task automatic tk(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : tk

   task automatic upd_gap(output int n);
      n = 0;
      while (upd !== 1'b1 && n < 400) begin
         tk(1);
         n++;
      end
      tk(1);
      n = 1;
      while (upd !== 1'b1 && n < 400) begin
         tk(1);
         n++;
      end
      if (n >= 400) begin
         miss(n, 32'h0);
         complete_run();
      end
   endtask : upd_gap

   // two full periods of ten make the count independent of phase
   task automatic hi20(input int eref, input int eout);
      int a;
      int b;
      a = 0;
      b = 0;
      tk(12);
      repeat (20) begin
         tk(1);
         a += int'(ch_ref === 1'b1);
         b += int'(ch_out === 1'b1);
      end
      chk(a, eref);
      chk(b, eout);
   endtask : hi20

   // counter is frozen so the captured value is known beforehand
   task automatic cap(input logic [11:0] c);
      logic [15:0] k;
      k = 16'(xs()) | 16'h1;
      wr(stcap_pkg::OFF_CCEN, 32'h0);
      wr(stcap_pkg::OFF_MODE, {30'h0, c[11:10]});
      rd(stcap_pkg::OFF_MODE, {30'h0, c[11:10]});
      wr(stcap_pkg::OFF_OPT, {30'h0, c[9:8]});
      src_r <= c[1] ? 6'h00 : 6'h3f;
      wr(stcap_pkg::OFF_CNT, {16'h0, k});
      wr(stcap_pkg::OFF_CHVAL, 32'h0);
      wr(stcap_pkg::OFF_STS, 32'h3);
      wr(stcap_pkg::OFF_CCEN, {28'h0, c[7], 1'b0, c[6], c[2]});
      @(posedge pclk);
      src_r[c[5:3]] <= c[1];
      tk(4);
      rd(stcap_pkg::OFF_CHVAL, c[0] ? {16'h0, k} : 32'h0);
      rd(stcap_pkg::OFF_STS, {30'h0, c[0], 1'b0});
      chk(irq, c[0]);
   endtask : cap

   // ======================================================
   // watchdog, far beyond the fewer than a thousand cycles the tests need
   initial begin
      #500000;
      err_total++;
      complete_run();
   end

   // ======================================================
   // main sequence
   initial begin
      int          g;
      logic [15:0] v;
      pclk = 0;
      presetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      src_r = 0;
      rng_r = 32'h0001_4081;
      err_total = 0;
      checked = 0;
      @(posedge pclk);
      #1 chk({27'h0, ch_oe, ch_out, upd, irq, pready}, 32'h0);
      @(posedge pclk);
      presetn <= 1'b1;
      rd(stcap_pkg::OFF_PRESC, 32'h0);
      rd(stcap_pkg::OFF_ARR, 32'hffff);
      rd(stcap_pkg::OFF_CHVAL, 32'h0);
      rd(stcap_pkg::OFF_OPT, 32'h0);
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'h44, 32'h5a5a, {1'b1, 32'h0});
      $display("test reset_values done");
      v = 16'(xs());
      wr(stcap_pkg::OFF_ARR, 32'h0);
      wr(stcap_pkg::OFF_CNT, {16'hffff, v});
      tk(8);
      rd(stcap_pkg::OFF_CNT, {16'h0, v});
      wr(stcap_pkg::OFF_PRESC, {16'h0, ~v});
      rd(stcap_pkg::OFF_PRESC, {16'h0, ~v});
      wr(stcap_pkg::OFF_PRESC, 32'h0);
      wr(stcap_pkg::OFF_OPT, 32'hffff);
      rd(stcap_pkg::OFF_OPT, 32'h3);
      $display("test register_access done");
      wr(stcap_pkg::OFF_MASK, 32'h1);
      // a random start above the limit would need a full 16-bit roll-over first
      wr(stcap_pkg::OFF_CNT, 32'h0);
      wr(stcap_pkg::OFF_ARR, 32'h5);
      upd_gap(g);
      upd_gap(g);
      chk(g, 6);
      chk(irq, 1'b1);
      wr(stcap_pkg::OFF_PRESC, 32'h3);
      upd_gap(g);
      upd_gap(g);
      chk(g, 24);
      wr(stcap_pkg::OFF_MASK, 32'h0);
      tk(2);
      chk(irq, 1'b0);
      wr(stcap_pkg::OFF_ARR, 32'h0);
      wr(stcap_pkg::OFF_STS, 32'h3);
      rd(stcap_pkg::OFF_STS, 32'h0);
      $display("test counting done");
      wr(stcap_pkg::OFF_PRESC, 32'h0);
      wr(stcap_pkg::OFF_CHVAL, 32'h4);
      wr(stcap_pkg::OFF_CCEN, 32'hb);
      rd(stcap_pkg::OFF_CCEN, 32'h3);
      wr(stcap_pkg::OFF_CCEN, 32'h1);
      wr(stcap_pkg::OFF_ARR, 32'h9);
      upd_gap(g);
      chk(ch_oe, 1'b1);
      hi20(8, 8);
      wr(stcap_pkg::OFF_CCEN, 32'h3);
      hi20(8, 12);
      wr(stcap_pkg::OFF_MODE, 32'h1);
      rd(stcap_pkg::OFF_MODE, 32'h0);
      wr(stcap_pkg::OFF_CCEN, 32'h0);
      hi20(8, 0);
      chk(ch_oe, 1'b0);
      $display("test output_compare done");
      wr(stcap_pkg::OFF_ARR, 32'h0);
      wr(stcap_pkg::OFF_CNT, 32'h3);
      tk(3);
      chk(ch_ref, 1'b1);
      wr(stcap_pkg::OFF_CHVAL, 32'h2);
      tk(3);
      chk(ch_ref, 1'b0);
      wr(stcap_pkg::OFF_CHVAL, 32'h4);
      wr(stcap_pkg::OFF_MODE, 32'h8);
      wr(stcap_pkg::OFF_CHVAL, 32'h2);
      tk(3);
      chk(ch_ref, 1'b1);
      wr(stcap_pkg::OFF_ARR, 32'h9);
      hi20(4, 0);
      wr(stcap_pkg::OFF_MODE, 32'h0);
      $display("test compare_preload done");
      wr(stcap_pkg::OFF_ARR, 32'h0);
      wr(stcap_pkg::OFF_MASK, 32'h2);
      for (int i = 0; i < 12; i++) begin
         cap(CASES[i]);
      end
      $display("test capture done");
      complete_run();
   end
endmodule : testbench
